// [src/ldp_pkg.sv]
// shared constants and types for the dot duty and mode map
package ldp_pkg;
    localparam int unsigned CLK_MHZ      = 100;
    localparam int unsigned ACTIVE_US    = 128;
    localparam int unsigned BLANK_US     = 8;
    localparam int unsigned ACTIVE_CYC   = ACTIVE_US * CLK_MHZ;
    localparam int unsigned BLANK_CYC    = BLANK_US * CLK_MHZ;
    localparam int unsigned DUTY_STEPS   = 256;
    localparam int unsigned ROWS         = 6;
    localparam int unsigned COLS         = 8;
    localparam int unsigned ARRAY_BYTES  = 192;
    localparam int unsigned ROW_STRIDE   = 16;
    localparam logic [7:0] PAGE_CONTROL  = 8'h00;
    localparam logic [7:0] PAGE_DUTY     = 8'h01;
    localparam logic [7:0] PAGE_BREATH   = 8'h02;
    localparam logic [7:0] PAGE_FUNC     = 8'h03;
    localparam logic [7:0] ARRAY_LAST    = 8'hBF;
    localparam logic [7:0] ADDR_PAGE_SEL = 8'hFD;
    localparam logic [7:0] ADDR_UNLOCK   = 8'hFE;
    localparam logic [7:0] ADDR_CONFIG   = 8'h00;
    localparam logic [7:0] ADDR_CUR_CODE = 8'h01;
    localparam logic [7:0] UNLOCK_KEY    = 8'hC5;
    localparam logic [7:0] UNLOCK_RST    = 8'h00;
    localparam logic [7:0] PAGE_RST      = 8'h00;
    localparam logic [7:0] BYTE_RST      = 8'h00;
    localparam logic [1:0] MODE_RST      = 2'h0;
    localparam int unsigned CFG_SSD_BIT  = 0;
    localparam int unsigned CFG_BEN_BIT  = 1;
    localparam logic [9:0] DUTY_SUM_MAX  = 10'h3FC;

    typedef enum logic [1:0] {
        LDP_MODE_PLAIN = 2'b00,
        LDP_MODE_ONE   = 2'b01,
        LDP_MODE_TWO   = 2'b10,
        LDP_MODE_THREE = 2'b11
    } ldp_mode_type;

    // one decoded register write from the serial port
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] data;
    } ldp_wr_type;
endpackage

// [src/ldp_dot_map.sv]
// dot duty and mode storage, row scan and column duty generation
//
// Contract
// - every dot owns four 8-bit duty bytes that combine into 1024 dimming steps.
// - each byte drives one current half of the column during one time half of the row.
// - average drive follows byte sum over 1024 times column current times scan duty.
// - six row phases each get 128 us active then 8 us blank, two halves per phase.
// - column current is scaled by the 8-bit global current code over 256.
// - the duty array spans 00h to BFh of its page, write only, resetting to zero.
// - a dot uses two adjacent offsets in two address rows 10h apart, first dot 00h 01h 10h 11h.
// - duty array sits on page 01h and the mode array on page 02h with the same layout.
// - each mode location keeps a 2-bit selector in D1:D0, upper bits unused, reset zero.
// - a dot whose four mode locations all hold 01h runs breath pattern one.
// - selector 00 is plain duty, 01 pattern one, 10 pattern two, 11 pattern three.
// - with the breath enable bit clear every dot runs plain duty control.
// - one page write is taken after C5h in the unlock register, which then clears to 00h.
module ldp_dot_map
    import ldp_pkg::*;
#(
    parameter int unsigned ACT_CYC = ACTIVE_CYC,
    parameter int unsigned BLK_CYC = BLANK_CYC
) (
    // clock and reset
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    // decoded register writes
    input  wire ldp_pkg::ldp_wr_type reg_i,
    // dot lookup
    input  wire logic [2:0]         dot_row_i,
    input  wire logic [2:0]         dot_col_i,
    output logic      [9:0]         dot_duty_sum_o,
    output logic      [1:0]         dot_mode_o,
    // drive outputs
    output logic      [5:0]         row_switch_line_o,
    output logic      [15:0]        column_source_line_o,
    output logic      [15:0]        column_mode_o,
    output logic      [7:0]         global_current_code_o,
    output logic      [7:0]         page_o
);
    import ldp_pkg::*;

    localparam int unsigned SLOT_CYC = ACT_CYC + BLK_CYC;
    localparam int unsigned HALF_CYC = ACT_CYC / 2;
    localparam int unsigned STEP_CYC = (HALF_CYC / DUTY_STEPS > 0) ? HALF_CYC / DUTY_STEPS : 1;
    localparam int unsigned CNT_W    = $clog2(SLOT_CYC + 1);
    localparam int unsigned STEP_W   = $clog2(STEP_CYC + 1);

    ////////////////////////////////////////////////////////////////////////////////
    // register port

    logic [7:0] duty_q [ARRAY_BYTES];
    logic [1:0] mode_q [ARRAY_BYTES];
    logic [7:0] page_q;
    logic [7:0] unlock_q;
    logic [7:0] code_q;
    logic [7:0] cfg_q;

    wire in_array   = reg_i.addr <= ARRAY_LAST;
    wire wr_unlock  = reg_i.wr && reg_i.addr == ADDR_UNLOCK;
    wire wr_page    = reg_i.wr && reg_i.addr == ADDR_PAGE_SEL && unlock_q == UNLOCK_KEY;
    wire wr_duty    = reg_i.wr && in_array && page_q == PAGE_DUTY;
    wire wr_mode    = reg_i.wr && in_array && page_q == PAGE_BREATH;
    wire wr_func    = reg_i.wr && page_q == PAGE_FUNC;
    wire wr_code    = wr_func && reg_i.addr == ADDR_CUR_CODE;
    wire wr_cfg     = wr_func && reg_i.addr == ADDR_CONFIG;
    wire ssd_on     = cfg_q[CFG_SSD_BIT];
    wire breath_en  = cfg_q[CFG_BEN_BIT];

    // arrays hold no read path: software can only write them
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < ARRAY_BYTES; i++) begin
                duty_q[i] <= BYTE_RST;
                mode_q[i] <= MODE_RST;
            end
        end else begin
            if (wr_duty) duty_q[reg_i.addr] <= reg_i.data;
            if (wr_mode) mode_q[reg_i.addr] <= reg_i.data[1:0];
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            page_q   <= PAGE_RST;
            unlock_q <= UNLOCK_RST;
            code_q   <= BYTE_RST;
            cfg_q    <= BYTE_RST;
        end else begin
            if (wr_page) page_q <= reg_i.data;
            if (wr_unlock) unlock_q <= reg_i.data;
            else if (wr_page) unlock_q <= UNLOCK_RST;
            if (wr_code) code_q <= reg_i.data;
            if (wr_cfg) cfg_q <= reg_i.data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // per dot decoding

    function automatic logic [7:0] dot_base(input logic [2:0] row, input logic [2:0] col);
        dot_base = 8'(row * 2 * ROW_STRIDE + col * 2);
    endfunction

    function automatic logic [9:0] dot_sum(input logic [7:0] b);
        dot_sum = 10'(duty_q[b]) + 10'(duty_q[b + 8'h01])
                + 10'(duty_q[b + 8'(ROW_STRIDE)])
                + 10'(duty_q[b + 8'(ROW_STRIDE + 1)]);
    endfunction

    // disagreeing locations fall back to plain duty rather than guessing a pattern
    function automatic logic [1:0] dot_mode(input logic [7:0] b);
        logic [1:0] m;
        m = mode_q[b];
        if (!breath_en) dot_mode = LDP_MODE_PLAIN;
        else if (m == mode_q[b + 8'h01] && m == mode_q[b + 8'(ROW_STRIDE)]
                 && m == mode_q[b + 8'(ROW_STRIDE + 1)]) dot_mode = m;
        else dot_mode = LDP_MODE_PLAIN;
    endfunction

    wire [7:0] look_base = dot_base(dot_row_i, dot_col_i);
    wire       look_ok   = dot_row_i < 3'(ROWS);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            dot_duty_sum_o <= 10'h000;
            dot_mode_o     <= MODE_RST;
        end else begin
            dot_duty_sum_o <= look_ok ? dot_sum(look_base) : 10'h000;
            dot_mode_o     <= look_ok ? dot_mode(look_base) : MODE_RST;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // row scan: active window in two halves, then blank

    logic [CNT_W-1:0]  cnt_q;
    logic [STEP_W-1:0] pre_q;
    logic [7:0]        pwm_q;
    logic [2:0]        row_q;

    wire slot_end = cnt_q == CNT_W'(SLOT_CYC - 1);
    wire active   = cnt_q < CNT_W'(ACT_CYC);
    wire half_hi  = cnt_q >= CNT_W'(HALF_CYC);
    wire half_beg = cnt_q == CNT_W'(HALF_CYC - 1);
    wire pre_end  = pre_q == STEP_W'(STEP_CYC - 1);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= '0;
            pre_q <= '0;
            pwm_q <= 8'h00;
            row_q <= 3'h0;
        end else begin
            cnt_q <= slot_end ? '0 : cnt_q + CNT_W'(1);
            if (slot_end || half_beg || pre_end) pre_q <= '0;
            else pre_q <= pre_q + STEP_W'(1);
            if (slot_end || half_beg) pwm_q <= 8'h00;
            else if (pre_end) pwm_q <= pwm_q + 8'h01;
            if (slot_end) row_q <= (row_q == 3'(ROWS - 1)) ? 3'h0 : row_q + 3'h1;
        end
    end

    wire [7:0] addr_row = 8'((row_q * 2 + {2'b00, half_hi}) * ROW_STRIDE);
    logic [15:0] col_d;
    logic [15:0] cmode_d;

    // bit 2c+h: column c, current half h taken from byte at even or odd offset
    for (genvar g = 0; g < 2 * COLS; g++) begin : g_col
        assign col_d[g] = ssd_on && active && pwm_q < duty_q[addr_row + 8'(g)];
    end
    for (genvar c = 0; c < COLS; c++) begin : g_mode
        assign cmode_d[2*c +: 2] = dot_mode(dot_base(row_q, 3'(c)));
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            row_switch_line_o    <= 6'h00;
            column_source_line_o <= 16'h0000;
            column_mode_o        <= 16'h0000;
        end else begin
            row_switch_line_o    <= (ssd_on && active) ? 6'(6'h01 << row_q) : 6'h00;
            column_source_line_o <= col_d;
            column_mode_o        <= cmode_d;
        end
    end

    assign global_current_code_o = code_q;
    assign page_o                = page_q;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    unlock_clear_a: assert property (wr_page && !wr_unlock
                                     |=> unlock_q == UNLOCK_RST)
        else $error("unlock not cleared after page write");
    page_lock_a: assert property (reg_i.wr && reg_i.addr == ADDR_PAGE_SEL
                                  && unlock_q != UNLOCK_KEY |=> $stable(page_q))
        else $error("page changed while locked");
    page_take_a: assert property (wr_page |=> page_o == $past(reg_i.data))
        else $error("unlocked page write lost");
    sum_range_a: assert property (dot_duty_sum_o <= DUTY_SUM_MAX)
        else $error("duty sum out of range");
    mode_plain_a: assert property (!breath_en ##1 !breath_en
                                   |-> dot_mode_o == 2'b00 && column_mode_o == 16'h0000)
        else $error("breath mode active while disabled");
    blank_dark_a: assert property (!active |=> row_switch_line_o == 6'h00
                                   && column_source_line_o == 16'h0000)
        else $error("drive during blanking");
    row_onehot_a: assert property ($onehot0(row_switch_line_o))
        else $error("more than one row switch on");
    row_step_a: assert property (!slot_end |=> $stable(row_q))
        else $error("row moved inside its slot");
    zero_dark_a: assert property (duty_q[addr_row] == 8'h00
                                  |=> !column_source_line_o[0])
        else $error("zero byte drove its column half");
    code_write_a: assert property (wr_code
                                   |=> global_current_code_o == $past(reg_i.data))
        else $error("current code write lost");

    page_switch_c: cover property (wr_unlock && reg_i.data == UNLOCK_KEY ##1 wr_page);
    row_wrap_c: cover property (slot_end && row_q == 3'(ROWS - 1));
    full_duty_c: cover property (dot_duty_sum_o == DUTY_SUM_MAX);
    breath_one_c: cover property (dot_mode_o == 2'b01);
endmodule

// [bench/ldp_host_model.sv]
// host model issuing decoded register writes to the dot map
module ldp_host_model
    import ldp_pkg::*;
(
    // clock
    input  wire logic         clk_i,
    // decoded write port
    output ldp_pkg::ldp_wr_type reg_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial reg_o = '{1'b0, 8'hFF, 8'hFF};

    ////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_o <= '{1'b1, a, d};
        @(posedge clk_i);
        // idle bus never shows the last value
        reg_o <= '{1'b0, ~a, ~d};
    endtask

    task automatic page(input logic [7:0] p);
        wr(ADDR_UNLOCK, UNLOCK_KEY);
        wr(ADDR_PAGE_SEL, p);
    endtask

    // caller passes one value four times for modes
    task automatic dot(input logic [2:0] r, c, input logic [7:0] a, b, x, y);
        logic [7:0] base;
        base = {r, 5'h00} | {4'h0, c, 1'b0};
        wr(base, a);
        wr(base + 8'h01, b);
        wr(base + 8'h10, x);
        wr(base + 8'h11, y);
    endtask
endmodule

// [bench/ldp_dot_map_tb.sv]
// self-checking bench for the dot duty and mode map
module ldp_dot_map_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ldp_pkg::*;

    // short scan so a full frame fits the run
    localparam int unsigned ACT = 512;
    localparam int unsigned BLK = 32;

    logic       clk_i;
    logic       rst_i;
    ldp_wr_type reg_w;
    logic [2:0] dot_row;
    logic [2:0] dot_col;
    logic [9:0] dot_duty_sum_o;
    logic [1:0] dot_mode_o;
    logic [5:0] row_sw;
    logic [15:0] col_src;
    logic [7:0] cur_code;
    logic [15:0] col_mode;
    logic [7:0] page_o;
    logic [7:0] v;
    int         fails;
    int         compares;
    int         n;

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    ldp_dot_map #(.ACT_CYC(ACT), .BLK_CYC(BLK)) dut_u (
        .clk_i                (clk_i),
        .rst_i                (rst_i),
        .reg_i                (reg_w),
        .dot_row_i            (dot_row),
        .dot_col_i            (dot_col),
        .dot_duty_sum_o       (dot_duty_sum_o),
        .dot_mode_o           (dot_mode_o),
        .row_switch_line_o    (row_sw),
        .column_source_line_o (col_src),
        .column_mode_o        (col_mode),
        .global_current_code_o(cur_code),
        .page_o               (page_o)
    );

    ldp_host_model host_u (
        .clk_i(clk_i),
        .reg_o(reg_w)
    );

    ////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic look(input logic [2:0] r, c, input logic [9:0] s, input logic [1:0] m);
        @(posedge clk_i);
        dot_row <= r;
        dot_col <= c;
        repeat (2) @(posedge clk_i);
        #1;
        chk("duty sum", 16'(s), 16'(dot_duty_sum_o));
        chk("dot mode", 16'(m), 16'(dot_mode_o));
    endtask

    // bounded wait for one row phase to begin
    task automatic wait_row(input logic [5:0] r);
        n = 0;
        while (row_sw !== r && n < 5000) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        chk("row wait", 16'(r), 16'(row_sw));
    endtask

    task automatic wrap_up();
        if (fails == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////
    initial begin
        #500000;
        fails++;
        wrap_up();
    end

    initial begin
        fails = 0;
        compares = 0;
        rst_i = 1'b1;
        dot_row = 3'h0;
        dot_col = 3'h0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        look(3'h0, 3'h0, 10'h000, 2'h0);
        chk("code reset", 16'h0000, 16'(cur_code));
        host_u.wr(ADDR_PAGE_SEL, PAGE_DUTY);
        #1 chk("locked page", 16'h0000, 16'(page_o));
        host_u.page(PAGE_DUTY);
        #1 chk("page", 16'h0001, 16'(page_o));
        host_u.wr(ADDR_PAGE_SEL, PAGE_BREATH);
        #1 chk("relock", 16'h0001, 16'(page_o));
        host_u.dot(3'h0, 3'h0, 8'hFF, 8'hFF, 8'hFF, 8'hFF);
        look(3'h0, 3'h0, 10'h3FC, 2'h0);
        host_u.dot(3'h5, 3'h7, 8'h80, 8'h80, 8'h80, 8'h00);
        look(3'h5, 3'h7, 10'h180, 2'h0);
        host_u.page(PAGE_FUNC);
        host_u.wr(ADDR_CONFIG, 8'h03);
        host_u.wr(ADDR_CUR_CODE, 8'hB5);
        #1 chk("current code", 16'h00B5, 16'(cur_code));
        host_u.page(PAGE_BREATH);
        for (int m = 0; m < 4; m++) begin
            v = {6'h3F, 2'(m)};
            host_u.dot(3'h0, 3'h0, v, v, v, v);
            look(3'h0, 3'h0, 10'h3FC, 2'(m));
        end
        // one location out of step: disagreeing locations give plain
        host_u.wr(8'h10, 8'h01);
        look(3'h0, 3'h0, 10'h3FC, 2'h0);
        host_u.wr(8'h10, 8'h03);
        look(3'h0, 3'h0, 10'h3FC, 2'h3);
        wait_row(6'h01);
        chk("column mode", 16'h0003, col_mode);
        // mode locations now agree, so only the enable bit can force plain
        host_u.page(PAGE_FUNC);
        host_u.wr(ADDR_CONFIG, 8'h01);
        look(3'h0, 3'h0, 10'h3FC, 2'h0);
        chk("column plain", 16'h0000, col_mode);
        wait_row(6'h02);
        n = 0;
        while (row_sw === 6'h02 && n < 5000) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        chk("active span", 16'(ACT), 16'(n));
        n = 0;
        while (row_sw === 6'h00 && n < 5000) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        chk("blank span", 16'(BLK), 16'(n));
        chk("next row", 16'h0004, 16'(row_sw));
        // last row holds bytes 80h 80h 80h 00h in column 7
        wait_row(6'h20);
        repeat (10) @(posedge clk_i);
        #1 chk("first half", 16'hC000, col_src);
        repeat (190) @(posedge clk_i);
        #1 chk("duty off", 16'h0000, col_src);
        repeat (66) @(posedge clk_i);
        #1 chk("second half", 16'h4000, col_src);
        wait_row(6'h01);
        repeat (10) @(posedge clk_i);
        #1 chk("column drive", 16'h0003, col_src);
        wrap_up();
    end
endmodule
